// ---- tser_pkg.sv ----
// Summary of operation
// - hw/testfn event query returns held events, then clears that event register.
// - clear-status, device-clear and reset clear every event register.
// - group summary is OR of events gated by writable, readable enable mask.
// - rising filter bits make a 0-to-1 status change set the event bit.
// - falling filter bits make a 1-to-0 status change set the event bit.
// - OR of enabled status byte bits going from false to true raises service request.
// - serial poll returns status byte, then clears request-service bit.
// - state query returns live status and changes nothing.
// - hw bit1 clock out of sync, bit2 drivers active, bit3 clock running.
// - hw bit4 sequencer armed or active unfinished; bit5 sequencer running.
// - testfn bit1 set when the last test failed.
// - syntax error flags command error, discards data until terminator.
// - range, restriction or state conflict raises execution error.
// - partial pin failure still applies command to passing pins.
// - state conflict alters state and flags autocorrection.
// - command, execution, autocorrection errors set own event status flags.
// - ten-entry error queue; overflow overwrites newest slot with overflow code.
// - error queue emptied on read, clear-status and device-clear.
// - queue entry holds error code, command token or zero, pin list.
// - self-test reports held as major/minor pairs; status byte bit 7 while pending.
// - after end-or-identify byte, hold handshake until pending data processed.
// - status byte bit0 hw, bit1 testfn, bit5 standard event, bit6 request.
// - event status bit5 command, bit4 execution, bit3 autocorrection.
// - event bits stay set until their register is cleared.
package tser_pkg;
   localparam int TSER_QDEPTH = 10;
   localparam int TSER_QPTR_W = 4;
   localparam logic [7:0] TSER_RST8 = 8'h00;
   localparam logic [7:0] TSER_OVF_CODE = 8'hff;
   localparam int TSER_HW_SYNC = 1;
   localparam int TSER_HW_DRV = 2;
   localparam int TSER_HW_CLK = 3;
   localparam int TSER_HW_BUSY = 4;
   localparam int TSER_HW_RUN = 5;
   localparam int TSER_TF_FAIL = 1;
   localparam int TSER_SB_HW = 0;
   localparam int TSER_SB_TF = 1;
   localparam int TSER_SB_MAV = 4;
   localparam int TSER_SB_ESB = 5;
   localparam int TSER_SB_RQS = 6;
   localparam int TSER_SB_SELF = 7;
   localparam int TSER_ES_CME = 5;
   localparam int TSER_ES_EXE = 4;
   localparam int TSER_ES_ATC = 3;
   typedef struct packed {
      logic [7:0] code;
      logic [7:0] token;
      logic [15:0] pins;
   } tser_err_s;
   typedef struct packed {
      logic [7:0] major;
      logic [7:0] minor;
   } tser_self_s;
   typedef enum logic [1:0] {TSER_W_EN, TSER_W_RS, TSER_W_FL} tser_wsel_e;
endpackage

// ---- tser_group.sv ----
`timescale 1ns/1ps
module tser_group
   import tser_pkg::*;
(
   // clock, reset, enable
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // live status and clears
   input wire logic [7:0] state_i,
   input wire logic clear_all_i,
   // command port
   input wire logic wr_i,
   input wire tser_wsel_e wsel_i,
   input wire logic [7:0] wdata_i,
   input wire logic evq_i,
   // readback
   output logic [7:0] event_o,
   output logic [7:0] enable_o,
   output logic [7:0] rise_o,
   output logic [7:0] fall_o,
   output logic summary_o
);
   logic [7:0] prev_reg, prev_next, ev_reg, ev_next, en_reg, en_next, rs_reg, rs_next, fl_reg, fl_next;
   logic [7:0] strobe;
   // one-cycle transition strobe against last sample
   assign strobe = (rs_reg & state_i & ~prev_reg) | (fl_reg & ~state_i & prev_reg);
   // next values: sticky events, set beats clear
   always_comb begin
      prev_next = state_i;
      ev_next = ev_reg;
      if (evq_i || clear_all_i) begin
         ev_next = TSER_RST8;
      end
      ev_next = ev_next | strobe;
      en_next = en_reg;
      rs_next = rs_reg;
      fl_next = fl_reg;
      if (wr_i) begin
         case (wsel_i)
            TSER_W_EN: en_next = wdata_i;
            TSER_W_RS: rs_next = wdata_i;
            TSER_W_FL: fl_next = wdata_i;
            default: en_next = en_reg;
         endcase
      end
   end
   // register update
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_reg <= TSER_RST8;
         ev_reg <= TSER_RST8;
         en_reg <= TSER_RST8;
         rs_reg <= TSER_RST8;
         fl_reg <= TSER_RST8;
      end else if (ce_i) begin
         prev_reg <= prev_next;
         ev_reg <= ev_next;
         en_reg <= en_next;
         rs_reg <= rs_next;
         fl_reg <= fl_next;
      end
   end
   assign event_o = ev_reg;
   assign enable_o = en_reg;
   assign rise_o = rs_reg;
   assign fall_o = fl_reg;
   assign summary_o = |(ev_reg & en_reg);

   a_event_sticky: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ce_i && !evq_i && !clear_all_i && |ev_reg |=> (ev_reg & $past(ev_reg)) == $past(ev_reg))
      else $error("event bit lost");
   a_rise_sets: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ce_i && |(rs_reg & state_i & ~prev_reg) |=> |(ev_reg & $past(rs_reg & state_i & ~prev_reg)))
      else $error("rising edge not captured");
   a_fall_sets: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ce_i && |(fl_reg & ~state_i & prev_reg) |=> |(ev_reg & $past(fl_reg & ~state_i & prev_reg)))
      else $error("falling edge not captured");
   a_query_clears: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ce_i && evq_i && strobe == 8'h00 |=> ev_reg == 8'h00)
      else $error("event query did not clear");
   a_summary_or: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ce_i && !evq_i && !clear_all_i && !wr_i && |(strobe & en_reg) |=> summary_o)
      else $error("summary not raised by enabled event");
   c_rise_event: cover property (@(posedge core_clk_i) disable iff (reset_i) ce_i && |(strobe & rs_reg));
endmodule

// ---- tser_top.sv ----
`timescale 1ns/1ps
module tser_top
   import tser_pkg::*;
(
   // clock, reset, enable
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // hardware and test state pins (asynchronous)
   input wire logic clk_out_of_sync_i,
   input wire logic drivers_active_i,
   input wire logic clock_running_i,
   input wire logic seq_armed_i,
   input wire logic seq_running_i,
   input wire logic test_done_i,
   input wire logic last_test_failed_i,
   // command decode strobes
   input wire logic clear_status_i,
   input wire logic device_clear_i,
   input wire logic hw_wr_i,
   input wire logic tf_wr_i,
   input wire tser_wsel_e wsel_i,
   input wire logic [7:0] wdata_i,
   input wire logic sre_wr_i,
   input wire logic ese_wr_i,
   input wire logic hw_event_query_i,
   input wire logic testfn_event_query_i,
   input wire logic serial_poll_i,
   input wire logic message_avail_i,
   // parser error reports
   input wire logic syntax_err_i,
   input wire logic exec_err_i,
   input wire logic autocorr_i,
   input wire tser_err_s err_i,
   input wire logic terminator_i,
   // error queue read
   input wire logic error_queue_query_i,
   input wire logic err_pop_i,
   // self-test reports
   input wire logic self_push_i,
   input wire tser_self_s self_i,
   input wire logic self_pop_i,
   // bus handshake
   input wire logic byte_valid_i,
   input wire logic byte_eoi_i,
   input wire logic pending_empty_i,
   // readback
   output logic [7:0] hw_state_o,
   output logic [7:0] testfn_state_o,
   output logic [7:0] hw_event_o,
   output logic [7:0] hw_enable_o,
   output logic [7:0] hw_rise_o,
   output logic [7:0] hw_fall_o,
   output logic [7:0] testfn_event_o,
   output logic [7:0] testfn_enable_o,
   output logic [7:0] testfn_rise_o,
   output logic [7:0] testfn_fall_o,
   output logic [7:0] status_byte_o,
   output logic [7:0] event_status_o,
   output logic [7:0] sre_o,
   output logic [7:0] ese_o,
   output logic srq_o,
   output logic discard_o,
   output logic handshake_hold_o,
   output tser_err_s err_head_o,
   output logic err_valid_o,
   output tser_self_s self_o,
   output logic self_valid_o
);
   logic [7:0] sync1_reg, sync2_reg, raw, hw_reg, hw_next, tf_reg, tf_next;
   logic clr_all, hw_sum, tf_sum, esb, mss;
   logic [7:0] es_reg, es_next, sre_reg, sre_next, ese_reg, ese_next, sb_base;
   logic rqs_reg, rqs_next, mss_reg, disc_reg, disc_next, hold_reg, hold_next;
   tser_err_s q_mem [TSER_QDEPTH];
   logic [TSER_QPTR_W-1:0] q_cnt_reg, q_cnt_next;
   tser_self_s self_reg, self_next;
   logic self_v_reg, self_v_next;
   logic [7:0] hw_ev, hw_en, tf_ev, tf_en;
   logic err_any;

   assign clr_all = clear_status_i || device_clear_i;
   // raw pins only, no logic ahead of the synchroniser; bit0 carries test done
   assign raw = {1'b0, 1'b0, seq_running_i, seq_armed_i, clock_running_i, drivers_active_i, clk_out_of_sync_i,
                 test_done_i};
   // live state after two-stage synchroniser; busy is armed or running, not finished
   always_comb begin
      hw_next = {2'b00, sync2_reg[5], (sync2_reg[4] || sync2_reg[5]) && !sync2_reg[0], sync2_reg[3:1],
                 1'b0};
      tf_next = {6'h00, sync2_reg[7], 1'b0};
   end
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync1_reg <= TSER_RST8;
         sync2_reg <= TSER_RST8;
         hw_reg <= TSER_RST8;
         tf_reg <= TSER_RST8;
      end else if (ce_i) begin
         sync1_reg <= {last_test_failed_i, raw[6:0]};
         sync2_reg <= sync1_reg;
         hw_reg <= hw_next;
         tf_reg <= tf_next;
      end
   end
   assign hw_state_o = hw_reg;
   assign testfn_state_o = tf_reg;

   // two identical status groups
   tser_group u_hw (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i), .state_i(hw_reg),
      .clear_all_i(clr_all), .wr_i(hw_wr_i), .wsel_i(wsel_i), .wdata_i(wdata_i), .evq_i(hw_event_query_i),
      .event_o(hw_ev), .enable_o(hw_en), .rise_o(hw_rise_o), .fall_o(hw_fall_o), .summary_o(hw_sum));
   tser_group u_tf (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i), .state_i(tf_reg),
      .clear_all_i(clr_all), .wr_i(tf_wr_i), .wsel_i(wsel_i), .wdata_i(wdata_i), .evq_i(testfn_event_query_i),
      .event_o(tf_ev), .enable_o(tf_en), .rise_o(testfn_rise_o), .fall_o(testfn_fall_o), .summary_o(tf_sum));
   assign hw_event_o = hw_ev;
   assign hw_enable_o = hw_en;
   assign testfn_event_o = tf_ev;
   assign testfn_enable_o = tf_en;

   // status byte, summaries, service request
   assign esb = |(es_reg & ese_reg);
   always_comb begin
      sb_base = TSER_RST8;
      sb_base[TSER_SB_HW] = hw_sum;
      sb_base[TSER_SB_TF] = tf_sum;
      sb_base[TSER_SB_MAV] = message_avail_i;
      sb_base[TSER_SB_ESB] = esb;
      sb_base[TSER_SB_SELF] = self_v_reg;
   end
   assign mss = |(sb_base & sre_reg);
   assign err_any = syntax_err_i || exec_err_i || autocorr_i;
   always_comb begin
      es_next = clr_all ? TSER_RST8 : es_reg;
      es_next[TSER_ES_CME] = es_next[TSER_ES_CME] | syntax_err_i;
      es_next[TSER_ES_EXE] = es_next[TSER_ES_EXE] | exec_err_i;
      es_next[TSER_ES_ATC] = es_next[TSER_ES_ATC] | autocorr_i;
      sre_next = sre_wr_i ? wdata_i : sre_reg;
      ese_next = ese_wr_i ? wdata_i : ese_reg;
      rqs_next = rqs_reg;
      if (serial_poll_i) begin
         rqs_next = 1'b0;
      end
      if (mss && !mss_reg) begin
         rqs_next = 1'b1;
      end
      disc_next = disc_reg;
      if (terminator_i) begin
         disc_next = 1'b0;
      end
      if (syntax_err_i) begin
         disc_next = 1'b1;
      end
      hold_next = hold_reg;
      if (hold_reg && pending_empty_i) begin
         hold_next = 1'b0;
      end
      if (byte_valid_i && byte_eoi_i) begin
         hold_next = 1'b1;
      end
   end
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         es_reg <= TSER_RST8;
         sre_reg <= TSER_RST8;
         ese_reg <= TSER_RST8;
         rqs_reg <= 1'b0;
         mss_reg <= 1'b0;
         disc_reg <= 1'b0;
         hold_reg <= 1'b0;
      end else if (ce_i) begin
         es_reg <= es_next;
         sre_reg <= sre_next;
         ese_reg <= ese_next;
         rqs_reg <= rqs_next;
         mss_reg <= mss;
         disc_reg <= disc_next;
         hold_reg <= hold_next;
      end
   end
   assign status_byte_o = sb_base | {1'b0, rqs_reg, 6'h00};
   assign event_status_o = es_reg;
   assign sre_o = sre_reg;
   assign ese_o = ese_reg;
   assign srq_o = rqs_reg;
   assign discard_o = disc_reg || syntax_err_i;
   assign handshake_hold_o = hold_reg;

   // error queue: head at slot 0, shifts on pop, newest slot overwritten on overflow
   always_comb begin
      q_cnt_next = q_cnt_reg;
      if (err_pop_i && q_cnt_reg != '0) begin
         q_cnt_next = q_cnt_reg - 4'h1;
      end
      if (err_any && q_cnt_next < 4'(TSER_QDEPTH)) begin
         q_cnt_next = q_cnt_next + 4'h1;
      end
      if (error_queue_query_i || clr_all) begin
         q_cnt_next = '0;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (ce_i && !error_queue_query_i && !clr_all) begin
         if (err_pop_i && q_cnt_reg != '0) begin
            for (int i = 0; i < TSER_QDEPTH - 1; i++) begin
               q_mem[i] <= q_mem[i+1];
            end
         end
         if (err_any) begin
            // full with no pop in the same cycle: newest slot takes the overflow mark
            if (q_cnt_reg == 4'(TSER_QDEPTH) && !err_pop_i) begin
               q_mem[TSER_QDEPTH-1] <= '{code: TSER_OVF_CODE, token: 8'h00, pins: 16'h0000};
            end else begin
               q_mem[q_cnt_next - 4'h1] <= err_i;
            end
         end
      end
   end
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         q_cnt_reg <= '0;
      end else if (ce_i) begin
         q_cnt_reg <= q_cnt_next;
      end
   end
   assign err_valid_o = q_cnt_reg != '0;
   assign err_head_o = err_valid_o ? q_mem[0] : '0;

   // self-test report holder
   always_comb begin
      self_next = self_reg;
      self_v_next = self_v_reg;
      if (self_pop_i) begin
         self_v_next = 1'b0;
      end
      if (self_push_i) begin
         self_next = self_i;
         self_v_next = 1'b1;
      end
   end
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         self_reg <= '0;
         self_v_reg <= 1'b0;
      end else if (ce_i) begin
         self_reg <= self_next;
         self_v_reg <= self_v_next;
      end
   end
   assign self_o = self_reg;
   assign self_valid_o = self_v_reg;

   a_srq_raise: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ce_i && mss && !mss_reg |=> srq_o)
      else $error("service request missing");
   a_poll_clears: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ce_i && serial_poll_i && !(mss && !mss_reg) |=> !srq_o)
      else $error("poll did not clear request");
   a_cme_flag: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ce_i && syntax_err_i |=> event_status_o[TSER_ES_CME] && discard_o)
      else $error("command error not flagged");
   a_hold_eoi: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ce_i && byte_valid_i && byte_eoi_i |=> handshake_hold_o)
      else $error("holdoff missing");
   a_queue_cap: assert property (@(posedge core_clk_i) disable iff (reset_i)
      q_cnt_reg <= 4'(TSER_QDEPTH))
      else $error("queue over depth");
   a_clr_empties: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ce_i && clr_all && !err_any |=> !err_valid_o && event_status_o == 8'h00 && hw_event_o == $past(u_hw.strobe))
      else $error("clear incomplete");
   c_srq: cover property (@(posedge core_clk_i) srq_o ##1 serial_poll_i);
   c_overflow: cover property (@(posedge core_clk_i) q_cnt_reg == 4'(TSER_QDEPTH) && err_any);
   c_hold: cover property (@(posedge core_clk_i) handshake_hold_o ##1 !handshake_hold_o);
endmodule

// ---- tser_ctrl_model.sv ----
`timescale 1ns/1ps
module tser_ctrl_model
   import tser_pkg::*;
(
   // clock, reset, pacing
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [3:0] delay_i,
   // device answers
   input wire logic srq_i,
   input wire logic [7:0] status_byte_i,
   input wire logic [7:0] hw_event_i,
   // requests
   output logic serial_poll_o,
   output logic hw_event_query_o,
   // what the controller read
   output logic seen_o,
   output logic [7:0] seen_data_o,
   output logic busy_o
);
   // service sequence: wait, poll, then event query of the hw group whichever group is flagged
   initial begin
      serial_poll_o = 1'b0;
      hw_event_query_o = 1'b0;
      seen_o = 1'b0;
      seen_data_o = 8'h00;
      busy_o = 1'b0;
      forever begin
         @(negedge core_clk_i);
         if (!reset_i && srq_i === 1'b1) begin
            busy_o = 1'b1;
            repeat (delay_i) @(negedge core_clk_i);
            serial_poll_o = 1'b1;
            #1 seen_data_o = status_byte_i;
            seen_o = 1'b1;
            @(negedge core_clk_i);
            serial_poll_o = 1'b0;
            hw_event_query_o = 1'b1;
            #1 seen_data_o = hw_event_i;
            @(negedge core_clk_i);
            hw_event_query_o = 1'b0;
            seen_o = 1'b0;
            busy_o = 1'b0;
         end
      end
   end
endmodule

// ---- tester_status_event_reporting_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tester_status_event_reporting_tb;
   import tser_pkg::*;
   logic core_clk_i = 0, reset_i = 1, ce_i = 0, message_avail_i = 0;
   logic clk_out_of_sync_i = 0, drivers_active_i = 0, clock_running_i = 0, seq_armed_i = 0, seq_running_i = 0;
   logic test_done_i = 0, last_test_failed_i = 0, clear_status_i = 0, device_clear_i = 0, hw_wr_i = 0, tf_wr_i = 0;
   logic sre_wr_i = 0, ese_wr_i = 0, testfn_event_query_i = 0, syntax_err_i = 0, exec_err_i = 0, autocorr_i = 0;
   logic terminator_i = 0, error_queue_query_i = 0, err_pop_i = 0, self_push_i = 0, self_pop_i = 0;
   logic byte_valid_i = 0, byte_eoi_i = 0, pending_empty_i = 1, serial_poll_i, hw_event_query_i;
   tser_wsel_e wsel_i = TSER_W_EN;
   logic [7:0] wdata_i = 8'h00;
   tser_err_s err_i = '0;
   tser_self_s self_i = '0;
   logic [7:0] hw_state_o, testfn_state_o, hw_event_o, hw_enable_o, hw_rise_o, hw_fall_o, testfn_event_o;
   logic [7:0] testfn_enable_o, testfn_rise_o, testfn_fall_o, status_byte_o, event_status_o, sre_o, ese_o;
   logic srq_o, discard_o, handshake_hold_o, err_valid_o, self_valid_o, seen, mbusy;
   tser_err_s err_head_o;
   tser_self_s self_o;
   logic [7:0] seen_data, rng = 8'h1c, r, mexp, es;
   logic [3:0] mdelay = 4'h0;
   logic [7:0] q[$];
   int errors = 0, n_checks = 0, cyc = 0;

   tser_top uut (.core_clk_i, .reset_i, .ce_i, .clk_out_of_sync_i, .drivers_active_i, .clock_running_i,
      .seq_armed_i, .seq_running_i, .test_done_i, .last_test_failed_i, .clear_status_i, .device_clear_i,
      .hw_wr_i, .tf_wr_i, .wsel_i, .wdata_i, .sre_wr_i, .ese_wr_i, .hw_event_query_i, .testfn_event_query_i,
      .serial_poll_i, .message_avail_i, .syntax_err_i, .exec_err_i, .autocorr_i, .err_i, .terminator_i,
      .error_queue_query_i, .err_pop_i, .self_push_i, .self_i, .self_pop_i, .byte_valid_i, .byte_eoi_i,
      .pending_empty_i, .hw_state_o, .testfn_state_o, .hw_event_o, .hw_enable_o, .hw_rise_o, .hw_fall_o,
      .testfn_event_o, .testfn_enable_o, .testfn_rise_o, .testfn_fall_o, .status_byte_o, .event_status_o,
      .sre_o, .ese_o, .srq_o, .discard_o, .handshake_hold_o, .err_head_o, .err_valid_o, .self_o, .self_valid_o);

   tser_ctrl_model ctrl (.core_clk_i(core_clk_i), .reset_i(reset_i), .delay_i(mdelay), .srq_i(srq_o),
      .status_byte_i(status_byte_o), .hw_event_i(hw_event_o), .serial_poll_o(serial_poll_i),
      .hw_event_query_o(hw_event_query_i), .seen_o(seen), .seen_data_o(seen_data), .busy_o(mbusy));

   // clock and hang guard
   always #2.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         $display("unexpected timeout exp done got hang");
         final_report();
      end
   end
   // compare each controller read with the oldest note
   always @(posedge core_clk_i) begin
      if (seen === 1'b1) begin
         mexp = (q.size() != 0) ? q.pop_front() : 8'hxx;
         `CHK("controller read", mexp, seen_data)
      end
   end

   function automatic logic [7:0] xs();
      rng ^= rng << 3;
      rng ^= rng >> 5;
      rng ^= rng << 1;
      return rng;
   endfunction
   task automatic tk(int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task automatic gw(logic hw, tser_wsel_e s, logic [7:0] d);
      @(negedge core_clk_i);
      hw_wr_i = hw;
      tf_wr_i = !hw;
      wsel_i = s;
      wdata_i = d;
      @(negedge core_clk_i);
      hw_wr_i = 0;
      tf_wr_i = 0;
   endtask
   task automatic er(int k, logic [7:0] c);
      @(negedge core_clk_i);
      err_i = '{c, 8'h11, 16'h0003};
      syntax_err_i = (k == 0);
      exec_err_i = (k == 1);
      autocorr_i = (k == 2);
      @(negedge core_clk_i);
      syntax_err_i = 0;
      exec_err_i = 0;
      autocorr_i = 0;
   endtask
   task automatic svc();
      for (int i = 0; i < 60 && (mbusy || srq_o || q.size() != 0); i++) tk(1);
      `CHK("pending reads", 0, q.size())
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      tk(4);
      reset_i = 0;
      ce_i = 1;
      `CHK("reset events", 8'h00, hw_event_o | testfn_event_o | event_status_o)
      `CHK("reset status byte", 8'h00, status_byte_o)
      for (int i = 0; i < 3; i++) begin
         r = xs();
         gw(1'b0, tser_wsel_e'(i), r);
         `CHK("tf masks", r, i == 0 ? testfn_enable_o : i == 1 ? testfn_rise_o : testfn_fall_o)
      end
      gw(1'b1, TSER_W_RS, 8'h05);
      gw(1'b1, TSER_W_FL, 8'h04);
      gw(1'b1, TSER_W_EN, 8'h05);
      sre_wr_i = 1;
      wdata_i = 8'h01;
      tk(1);
      sre_wr_i = 0;
      tk(1);
      `CHK("hw rise", 8'h05, hw_rise_o)
      `CHK("hw fall", 8'h04, hw_fall_o)
      `CHK("hw enable", 8'h05, hw_enable_o)
      `CHK("sre", 8'h01, sre_o)
      $display("test masks done");
      for (int i = 0; i < 2; i++) begin
         q.push_back(8'h41);
         q.push_back(8'h04);
         drivers_active_i = !i[0];
         tk(6);
         svc();
         `CHK("event after query", 8'h00, hw_event_o)
         `CHK("srq after poll", 1'b0, srq_o)
         `CHK("live state", i == 0 ? 8'h04 : 8'h00, hw_state_o)
      end
      mdelay = 4'hf;
      q.push_back(8'h41);
      q.push_back(8'h04);
      drivers_active_i = 1;
      tk(6);
      drivers_active_i = 0;
      tk(6);
      `CHK("sticky event", 8'h04, hw_event_o)
      svc();
      mdelay = 4'h0;
      clock_running_i = 1;
      clk_out_of_sync_i = 1;
      tk(6);
      `CHK("clock state", 8'h0a, hw_state_o)
      `CHK("unselected event", 8'h00, hw_event_o)
      for (int i = 0; i < 3; i++) begin
         seq_armed_i = (i != 1);
         seq_running_i = (i == 1);
         test_done_i = (i == 2);
         tk(6);
         `CHK("sequencer state", i == 0 ? 8'h1a : i == 1 ? 8'h3a : 8'h0a, hw_state_o)
      end
      $display("test hardware group done");
      gw(1'b0, TSER_W_RS, 8'h02);
      last_test_failed_i = 1;
      tk(6);
      `CHK("tf state", 8'h02, testfn_state_o)
      `CHK("tf event", 8'h02, testfn_event_o)
      testfn_event_query_i = 1;
      tk(1);
      testfn_event_query_i = 0;
      tk(1);
      `CHK("tf event read", 8'h00, testfn_event_o)
      gw(1'b0, TSER_W_FL, 8'h02);
      last_test_failed_i = 0;
      tk(6);
      `CHK("tf fall event", 8'h02, testfn_event_o)
      device_clear_i = 1;
      tk(1);
      device_clear_i = 0;
      tk(1);
      `CHK("device clear", 8'h00, testfn_event_o)
      $display("test function group done");
      es = 8'h00;
      for (int k = 0; k < 3; k++) begin
         er(k, 8'h10);
         es |= 8'h20 >> k;
         `CHK("event status", es, event_status_o)
         if (k == 0) begin
            `CHK("discard", 1'b1, discard_o)
            terminator_i = 1;
            tk(1);
            terminator_i = 0;
            tk(1);
            `CHK("discard end", 1'b0, discard_o)
         end
      end
      ese_wr_i = 1;
      wdata_i = 8'h38;
      message_avail_i = 1;
      tk(1);
      ese_wr_i = 0;
      tk(1);
      `CHK("status byte", 8'h30, status_byte_o)
      `CHK("ese", 8'h38, ese_o)
      error_queue_query_i = 1;
      tk(1);
      error_queue_query_i = 0;
      tk(1);
      `CHK("queue read empties", 1'b0, err_valid_o)
      for (int i = 1; i <= 11; i++) er(1, 8'(i));
      `CHK("queue head", 32'h01110003, err_head_o)
      for (int i = 0; i < 10; i++) begin
         tk(1);
         if (i == 9) `CHK("overflow code", TSER_OVF_CODE, err_head_o.code)
         err_pop_i = 1;
         tk(1);
         err_pop_i = 0;
      end
      tk(1);
      `CHK("queue depth", 1'b0, err_valid_o)
      er(2, 8'h22);
      clear_status_i = 1;
      tk(1);
      clear_status_i = 0;
      tk(1);
      `CHK("clear queue", 1'b0, err_valid_o)
      `CHK("clear event status", 8'h00, event_status_o)
      $display("test errors done");
      self_i = '{8'h03, 8'h07};
      self_push_i = 1;
      tk(1);
      self_push_i = 0;
      tk(1);
      `CHK("self report", 17'h10307, {status_byte_o[7], self_o})
      self_pop_i = 1;
      tk(1);
      self_pop_i = 0;
      tk(1);
      `CHK("self cleared", 1'b0, self_valid_o)
      pending_empty_i = 0;
      for (int i = 0; i < 2; i++) begin
         byte_valid_i = 1;
         byte_eoi_i = i[0];
         tk(1);
         byte_valid_i = 0;
         tk(2);
         `CHK("holdoff", i[0], handshake_hold_o)
      end
      pending_empty_i = 1;
      tk(2);
      `CHK("holdoff release", 1'b0, handshake_hold_o)
      $display("test self report and holdoff done");
      final_report();
   end
endmodule
